// *** common/tmr_pkg.sv ***
// Purpose: Shared constants and types for the channel 0 I/O control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Field nibbles hold {mode, initial level, action[1:0]}
package tmr_pkg;
    localparam int TMR_AW = 4;
    localparam logic [TMR_AW-1:0] TMR_OFF_IOC_HIGH = 4'h0;
    localparam logic [TMR_AW-1:0] TMR_OFF_IOC_LOW = 4'h4;
    localparam logic [TMR_AW-1:0] TMR_OFF_MODE = 4'h8;
    localparam logic [TMR_AW-1:0] TMR_OFF_STATUS = 4'hC;
    localparam logic [7:0] TMR_IOC_RST = 8'h00;
    localparam logic [2:0] TMR_MODE_RST = 3'h0;
    // Mode/control register bits
    localparam int TMR_BIT_RUN = 0;
    localparam int TMR_BIT_BUF_C = 1;
    localparam int TMR_BIT_BUF_D = 2;
    // Status register bits
    localparam int TMR_ST_PIN_A = 0;
    localparam int TMR_ST_PIN_D = 1;
    localparam int TMR_ST_DRV_A = 2;
    localparam int TMR_ST_DRV_D = 3;
    localparam int TMR_ST_IN_A = 4;
    localparam int TMR_ST_IN_D = 5;
    // Field bit positions inside a nibble
    localparam int TMR_F_CAP = 3;
    localparam int TMR_F_INIT = 2;
    // Field index: A, C, D
    localparam int TMR_FA = 0;
    localparam int TMR_FC = 1;
    localparam int TMR_FD = 2;
    localparam int TMR_NFLD = 3;
    localparam logic [1:0] TMR_CODE_NONE = 2'h0;
    localparam logic [1:0] TMR_CODE_LOW = 2'h1;
    localparam logic [1:0] TMR_CODE_HIGH = 2'h2;
    typedef enum logic [1:0] {TMR_ACT_NONE, TMR_ACT_LOW, TMR_ACT_HIGH, TMR_ACT_TOGGLE} tmr_act_t;
endpackage

// *** common/tmr_fld_if.sv ***
// Purpose: One control field and its decoded meaning
// Assumes: Decoder is purely combinational
// Notes: cfg side drives the raw field, dec side the meaning
interface tmr_fld_if;
    import tmr_pkg::*;
    logic [3:0] field;
    logic ignore;
    logic cmp_mode;
    logic oe;
    logic init_lvl;
    tmr_act_t act;
    logic cap_rise;
    logic cap_fall;
    modport cfg (output field, output ignore, input cmp_mode, input oe, input init_lvl, input act,
                 input cap_rise, input cap_fall);
    modport dec (input field, input ignore, output cmp_mode, output oe, output init_lvl, output act,
                 output cap_rise, output cap_fall);
endinterface

// *** design/tmr_fld_dec.sv ***
// Purpose: Decode one 4-bit I/O control field
// Assumes: ignore is high while the register serves as a buffer
// Notes: Prohibited codes decode to no function at all
module tmr_fld_dec (
    tmr_fld_if.dec f
);
    import tmr_pkg::*;
    logic cap_ok;
    always_comb
    begin
        f.cmp_mode = !f.field[TMR_F_CAP] && !f.ignore;
        f.oe = f.cmp_mode && (f.field[1:0] != TMR_CODE_NONE);
        f.init_lvl = f.field[TMR_F_INIT];
        case (f.field[1:0])
            TMR_CODE_NONE: f.act = TMR_ACT_NONE;
            TMR_CODE_LOW: f.act = TMR_ACT_LOW;
            TMR_CODE_HIGH: f.act = TMR_ACT_HIGH;
            default: f.act = TMR_ACT_TOGGLE;
        endcase
        // Codes 11xx do nothing rather than guess
        cap_ok = f.field[TMR_F_CAP] && !f.field[TMR_F_INIT] && !f.ignore;
        f.cap_rise = cap_ok && (f.field[1] || !f.field[0]);
        f.cap_fall = cap_ok && (f.field[1] || f.field[0]);
    end
endmodule // tmr_fld_dec

// *** design/tmr_io_ctrl.sv ***
// Purpose: Channel 0 I/O control: compare pin levels and capture strobes for A, C, D
// Assumes: Compare match inputs come from counter logic on pclk
// Notes: A and C share pin A; C acts after A in the same cycle
//
// Decided for this implementation: the address map and register access over APB.
module tmr_io_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmr_pkg::TMR_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_match_a,
    input wire logic cmp_match_c,
    input wire logic cmp_match_d,
    input wire logic ch0_pin_a_i,
    output logic ch0_pin_a_o,
    output logic ch0_pin_a_oe_n,
    input wire logic ch0_pin_d_i,
    output logic ch0_pin_d_o,
    output logic ch0_pin_d_oe_n,
    output logic capture_a,
    output logic capture_c,
    output logic capture_d
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] ioh_q, ioh_d, iol_q, iol_d;
    logic [2:0] mode_q, mode_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] status;
    logic mapped, setup, wr_ok;
    logic pa_q, pa_d, pd_q, pd_d, oea_q, oea_d, oed_q, oed_d;
    logic [2:0] sa_q, sd_q;
    logic la_q, la_d, ld_q, ld_d;
    logic [2:0] cap_q, cap_d;
    logic [3:0] fval [TMR_NFLD];

    assign mapped = (paddr[1:0] == 2'b00);
    assign setup = psel && !penable;
    assign wr_ok = psel && penable && pwrite && mapped && pstrb[0];
    // Read data latched in setup so prdata comes from a flop with no wait state
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_q;
    assign status = {26'h000_0000, ld_q, la_q, oed_q, oea_q, pd_q, pa_q};

    always_comb
    begin
        ioh_d = ioh_q;
        iol_d = iol_q;
        mode_d = mode_q;
        rdata_d = rdata_q;
        if (wr_ok)
        begin
            case (paddr)
                TMR_OFF_IOC_HIGH: ioh_d = pwdata[7:0];
                TMR_OFF_IOC_LOW: iol_d = pwdata[7:0];
                TMR_OFF_MODE: mode_d = pwdata[2:0];
                default: ;
            endcase
        end
        if (setup && !pwrite)
        begin
            case (paddr)
                TMR_OFF_IOC_HIGH: rdata_d = {24'h00_0000, ioh_q};
                TMR_OFF_IOC_LOW: rdata_d = {24'h00_0000, iol_q};
                TMR_OFF_MODE: rdata_d = {29'h0000_0000, mode_q};
                TMR_OFF_STATUS: rdata_d = status;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ioh_q <= TMR_IOC_RST;
            iol_q <= TMR_IOC_RST;
            mode_q <= TMR_MODE_RST;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ioh_q <= ioh_d;
            iol_q <= iol_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    tmr_fld_if fld [TMR_NFLD] ();
    assign fval[TMR_FA] = ioh_q[3:0];
    assign fval[TMR_FC] = iol_q[3:0];
    assign fval[TMR_FD] = iol_q[7:4];

    for (genvar i = 0; i < TMR_NFLD; i++)
    begin : g_fld
        assign fld[i].field = fval[i];
        if (i == TMR_FA)
        begin : g_a
            assign fld[i].ignore = 1'b0;
        end
        else if (i == TMR_FC)
        begin : g_c
            assign fld[i].ignore = mode_q[TMR_BIT_BUF_C];
        end
        else
        begin : g_d
            assign fld[i].ignore = mode_q[TMR_BIT_BUF_D];
        end
        tmr_fld_dec u_dec (
            .f(fld[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input filter and capture
    logic rise_a, fall_a, rise_d, fall_d;

    always_comb
    begin
        // Stage 0 is seen only by stage 1
        la_d = (sa_q[1] == sa_q[2]) ? sa_q[2] : la_q;
        ld_d = (sd_q[1] == sd_q[2]) ? sd_q[2] : ld_q;
        rise_a = la_d && !la_q;
        fall_a = !la_d && la_q;
        rise_d = ld_d && !ld_q;
        fall_d = !ld_d && ld_q;
        cap_d[TMR_FA] = (rise_a && fld[TMR_FA].cap_rise) || (fall_a && fld[TMR_FA].cap_fall);
        cap_d[TMR_FC] = (rise_a && fld[TMR_FC].cap_rise) || (fall_a && fld[TMR_FC].cap_fall);
        cap_d[TMR_FD] = (rise_d && fld[TMR_FD].cap_rise) || (fall_d && fld[TMR_FD].cap_fall);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sa_q <= 3'h0;
            sd_q <= 3'h0;
            la_q <= 1'b0;
            ld_q <= 1'b0;
            cap_q <= 3'h0;
        end
        else
        begin
            sa_q <= {sa_q[1:0], ch0_pin_a_i};
            sd_q <= {sd_q[1:0], ch0_pin_d_i};
            la_q <= la_d;
            ld_q <= ld_d;
            cap_q <= cap_d;
        end
    end

    assign capture_a = cap_q[TMR_FA];
    assign capture_c = cap_q[TMR_FC];
    assign capture_d = cap_q[TMR_FD];

    ////////////////////////////////////////////////////////////////////////
    // Compare outputs
    function automatic logic apply(logic lvl, tmr_act_t act, logic hit);
        logic r;
        r = lvl;
        if (hit)
        begin
            case (act)
                TMR_ACT_LOW: r = 1'b0;
                TMR_ACT_HIGH: r = 1'b1;
                TMR_ACT_TOGGLE: r = !lvl;
                default: r = lvl;
            endcase
        end
        return r;
    endfunction

    logic run;
    assign run = mode_q[TMR_BIT_RUN];

    always_comb
    begin
        pa_d = pa_q;
        pd_d = pd_q;
        if (!run)
        begin
            // While stopped the level tracks the field's initial setting
            if (fld[TMR_FA].cmp_mode)
                pa_d = fld[TMR_FA].init_lvl;
            else if (fld[TMR_FC].cmp_mode)
                pa_d = fld[TMR_FC].init_lvl;
            if (fld[TMR_FD].cmp_mode)
                pd_d = fld[TMR_FD].init_lvl;
        end
        else
        begin
            pa_d = apply(pa_q, fld[TMR_FA].act, cmp_match_a && fld[TMR_FA].cmp_mode);
            pa_d = apply(pa_d, fld[TMR_FC].act, cmp_match_c && fld[TMR_FC].cmp_mode);
            pd_d = apply(pd_q, fld[TMR_FD].act, cmp_match_d && fld[TMR_FD].cmp_mode);
        end
        oea_d = fld[TMR_FA].oe || fld[TMR_FC].oe;
        oed_d = fld[TMR_FD].oe;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_q <= 1'b0;
            pd_q <= 1'b0;
            oea_q <= 1'b0;
            oed_q <= 1'b0;
        end
        else
        begin
            pa_q <= pa_d;
            pd_q <= pd_d;
            oea_q <= oea_d;
            oed_q <= oed_d;
        end
    end

    assign ch0_pin_a_o = pa_q;
    assign ch0_pin_d_o = pd_q;
    assign ch0_pin_a_oe_n = !oea_q;
    assign ch0_pin_d_oe_n = !oed_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_init_low: assert property ((!run && ioh_q[3:2] == 2'b00) |=> !ch0_pin_a_o)
        else $error("pin A not low while stopped with initial low");
    a_init_high: assert property ((!run && ioh_q[3:2] == 2'b01) |=> ch0_pin_a_o)
        else $error("pin A not high while stopped with initial high");
    a_out_disabled: assert property ((iol_q[7] == 1'b0 && iol_q[5:4] == 2'b00) |=> ch0_pin_d_oe_n)
        else $error("pin D driven with output disabled code");
    a_match_action: assert property ((run && cmp_match_d && iol_q[7] == 1'b0 && !mode_q[TMR_BIT_BUF_D]
        && iol_q[5:4] != 2'b00) |=> ($past(iol_q[5:4]) == 2'b11) ? (pd_q != $past(pd_q))
        : (pd_q == $past(iol_q[5])))
        else $error("pin D wrong after compare match");
    a_cap_edges: assert property ((ioh_q[3:0] == 4'h8 && rise_a) |=> capture_a)
        else $error("rising capture on A missed");
    a_cap_fall_only: assert property ((ioh_q[3:0] == 4'h9 && rise_a) |=> !capture_a)
        else $error("falling-only capture fired on rising edge");
    a_cap_d_src: assert property (capture_d |-> $past(rise_d || fall_d))
        else $error("D capture without pin D edge");
    a_cap_c_src: assert property (capture_c |-> $past(rise_a || fall_a))
        else $error("C capture without pin A edge");
    a_buf_d_quiet: assert property ($past(mode_q[TMR_BIT_BUF_D]) |-> (!capture_d && ch0_pin_d_oe_n))
        else $error("buffered D still active");
    a_buf_c_quiet: assert property ($past(mode_q[TMR_BIT_BUF_C]) |-> !capture_c)
        else $error("buffered C still captures");
    a_run_hold: assert property ((run && !cmp_match_d) |=> $stable(ch0_pin_d_o))
        else $error("pin D moved while running without match");

    c_toggle_a: cover property (run && cmp_match_a ##1 run && cmp_match_a);
    c_cap_both: cover property (capture_a ##[1:20] capture_a);
    c_buf_switch: cover property (!mode_q[TMR_BIT_BUF_C] ##1 mode_q[TMR_BIT_BUF_C]);
    c_apb_err: cover property (pslverr);
endmodule // tmr_io_ctrl

// *** tb/tb_tmr_io_ctrl.sv ***
// Purpose: Self-checking bench for the channel 0 I/O control block
// Assumes: Zero-wait APB slave; bench drives pins and compare matches directly
// Notes: Capture fields and buffer bits drawn at random from seed 21
module tb_tmr_io_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [TMR_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, fa, fc, fd;
    logic cmp_match_a, cmp_match_c, cmp_match_d, capture_a, capture_c, capture_d;
    logic ch0_pin_a_i, ch0_pin_a_o, ch0_pin_a_oe_n, ch0_pin_d_i, ch0_pin_d_o, ch0_pin_d_oe_n;
    logic [7:0] d;
    logic [1:0] bb;
    logic la, ld;
    int errors, comparisons, seed, na, nc, nd;

    tmr_io_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_match_a(cmp_match_a), .cmp_match_c(cmp_match_c), .cmp_match_d(cmp_match_d),
        .ch0_pin_a_i(ch0_pin_a_i), .ch0_pin_a_o(ch0_pin_a_o), .ch0_pin_a_oe_n(ch0_pin_a_oe_n),
        .ch0_pin_d_i(ch0_pin_d_i), .ch0_pin_d_o(ch0_pin_d_o), .ch0_pin_d_oe_n(ch0_pin_d_oe_n),
        .capture_a(capture_a), .capture_c(capture_c), .capture_d(capture_d));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic [TMR_AW-1:0] a, input logic w, input logic [7:0] v, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, v};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            report_and_stop;
        end
    endtask

    task automatic wr(input logic [TMR_AW-1:0] a, input logic [7:0] v);
        apb(a, 1'b1, v, 4'h1);
    endtask

    function automatic logic [7:0] mode(input logic run, input logic bc, input logic bd);
        logic [7:0] m;
        m = 8'h00;
        m[TMR_BIT_RUN] = run;
        m[TMR_BIT_BUF_C] = bc;
        m[TMR_BIT_BUF_D] = bd;
        return m;
    endfunction

    function automatic logic cap_exp(input logic [3:0] f, input logic rise);
        return (f == 4'h8 && rise) || (f == 4'h9 && !rise) || f[3:1] == 3'b101;
    endfunction

    function automatic logic pin(input int sel);
        return sel == TMR_FD ? ch0_pin_d_o : ch0_pin_a_o;
    endfunction

    task automatic set_field(input int sel, input logic [3:0] c);
        wr(TMR_OFF_IOC_HIGH, sel == TMR_FA ? {4'h0, c} : 8'h00);
        wr(TMR_OFF_IOC_LOW, sel == TMR_FC ? {4'h0, c} : (sel == TMR_FD ? {c, 4'h0} : 8'h00));
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge pclk);
        {cmp_match_a, cmp_match_c, cmp_match_d} <= m;
        @(posedge pclk);
        {cmp_match_a, cmp_match_c, cmp_match_d} <= 3'b000;
        @(negedge pclk);
    endtask

    // C shares pin A with A; its stopped level loses to A, so only its match is judged
    task automatic cmp_test(input int sel, input logic [3:0] c);
        logic want;
        set_field(sel, c);
        wr(TMR_OFF_MODE, mode(1'b0, 1'b0, 1'b0));
        repeat (3) @(negedge pclk);
        if (sel != TMR_FC)
        begin
            chk(pin(sel), c[2], "initial level");
            chk(sel == TMR_FD ? ch0_pin_d_oe_n : ch0_pin_a_oe_n, c[1:0] == 2'b00, "drive enable");
        end
        wr(TMR_OFF_MODE, mode(1'b1, 1'b0, 1'b0));
        @(negedge pclk);
        want = c[1:0] == 2'b01 ? 1'b0 : (c[1:0] == 2'b10 ? 1'b1 : (c[1:0] == 2'b11 ? !pin(sel) : pin(sel)));
        pulse({sel == TMR_FA, sel == TMR_FC, sel == TMR_FD});
        chk(pin(sel), want, "level after match");
        set_field(sel, c ^ 4'h4);
        repeat (2) @(negedge pclk);
        chk(pin(sel), want, "level while running");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (60000) @(posedge pclk);
        errors++;
        report_and_stop;
    end

    initial
    begin
        seed = 21;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {cmp_match_a, cmp_match_c, cmp_match_d, ch0_pin_a_i, ch0_pin_d_i, la, ld} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(ch0_pin_a_oe_n, 1'b1, "reset drive A");
        for (int a = 0; a < 3; a++)
        begin
            apb(4'(a * 4), 1'b0, 8'h00, 4'h0);
            chk(rd, 32'h0000_0000, "reset value");
        end
        d = 8'($random(seed));
        d[3] = 1'b0;
        wr(TMR_OFF_IOC_HIGH, d);
        apb(TMR_OFF_IOC_HIGH, 1'b1, ~d, 4'h0);
        apb(4'h1, 1'b1, ~d, 4'h1);
        chk(err, 1'b1, "unaligned error");
        apb(TMR_OFF_IOC_HIGH, 1'b0, 8'h00, 4'h0);
        chk(rd, {24'h00_0000, d}, "read back");
        apb(4'h6, 1'b0, 8'h00, 4'h0);
        chk(err, 1'b1, "unaligned read error");
        chk(rd, 32'h0000_0000, "unaligned read data");
        for (int sel = 0; sel < TMR_NFLD; sel++)
            for (int c = 0; c < 8; c++)
                cmp_test(sel, 4'(c));
        // Buffered C and D: no drive, matches have no effect
        wr(TMR_OFF_IOC_HIGH, 8'h00);
        wr(TMR_OFF_IOC_LOW, 8'h22);
        wr(TMR_OFF_MODE, mode(1'b0, 1'b1, 1'b1));
        repeat (3) @(negedge pclk);
        chk(ch0_pin_d_oe_n, 1'b1, "buffered D drive");
        wr(TMR_OFF_MODE, mode(1'b1, 1'b1, 1'b1));
        pulse(3'b011);
        chk(ch0_pin_d_o, 1'b0, "buffered D match");
        chk(ch0_pin_a_o, 1'b0, "buffered C match");
        for (int i = 0; i < 12; i++)
        begin
            // First two rounds pin down the single-edge codes on A
            fa = (i < 2) ? 4'(8 + i) : {2'b10, 2'($random(seed))};
            fc = {2'b10, 2'($random(seed))};
            fd = {2'b10, 2'($random(seed))};
            bb = 2'($random(seed));
            wr(TMR_OFF_IOC_HIGH, {4'h0, fa});
            wr(TMR_OFF_IOC_LOW, {fd, fc});
            wr(TMR_OFF_MODE, mode(1'b1, bb[0], bb[1]));
            // One pin at a time, so a capture from the wrong source shows up
            for (int p = 0; p < 4; p++)
            begin
                @(posedge pclk);
                if (p[0])
                begin
                    ld = !ld;
                    ch0_pin_d_i <= ld;
                end
                else
                begin
                    la = !la;
                    ch0_pin_a_i <= la;
                end
                {na, nc, nd} = '0;
                repeat (10)
                begin
                    @(negedge pclk);
                    na += int'(capture_a === 1'b1);
                    nc += int'(capture_c === 1'b1);
                    nd += int'(capture_d === 1'b1);
                end
                chk(na, p[0] ? 1'b0 : cap_exp(fa, la), "capture A");
                chk(nc, (p[0] || bb[0]) ? 1'b0 : cap_exp(fc, la), "capture C");
                chk(nd, (!p[0] || bb[1]) ? 1'b0 : cap_exp(fd, ld), "capture D");
                // Pins idle low and undriven here, so only the filtered inputs show
                apb(TMR_OFF_STATUS, 1'b0, 8'h00, 4'h0);
                chk(rd, (32'(la) << TMR_ST_IN_A) | (32'(ld) << TMR_ST_IN_D), "status inputs");
            end
        end
        report_and_stop;
    end
endmodule // tb_tmr_io_ctrl
